// file: baet_pkg.sv
package baet_pkg;
   // ------------------------------------------------------------
   // Bus encodings
   // ------------------------------------------------------------
   localparam logic [1:0] BAET_TT_NORMAL = 2'h0;
   localparam logic [1:0] BAET_TT_ACK = 2'h3;
   localparam logic [31:0] BAET_ADDR_IACK = 32'hFFFF_FFFF;
   localparam logic [31:0] BAET_ADDR_BREAK = 32'h0000_0000;
   localparam logic [2:0] BAET_TM_BREAK = 3'h0;
   localparam logic [7:0] BAET_AUTOVEC_BASE = 8'h18;
   localparam logic [7:0] BAET_SPURIOUS_VEC = 8'h18;
   localparam logic [1:0] BAET_LINE_BEATS_M1 = 2'h3;
   localparam logic [1:0] BAET_MISALIGN_LAST = 2'h1;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      BAET_IDLE = 5'b00001,
      BAET_IACK = 5'b00010,
      BAET_BREAK = 5'b00100,
      BAET_XFER = 5'b01000,
      BAET_DONE = 5'b10000
   } baet_state_e;

   typedef enum logic [1:0] {
      BAET_TERM_WAIT = 2'h0,
      BAET_TERM_NORMAL = 2'h1,
      BAET_TERM_BERR = 2'h2,
      BAET_TERM_RETRY = 2'h3
   } baet_term_e;

   typedef struct packed {
      logic [1:0] transfer_type;
      logic [2:0] transfer_modifier;
      logic [31:0] addr;
      logic read;
   } baet_attr_s;

   // Normal access request from the memory units
   typedef struct packed {
      logic [31:0] addr;
      logic [2:0] tm;
      logic write;
      logic line;
      logic prefetch;
      logic misaligned;
      logic [1:0] wanted_beat;
      logic push;
      logic push_forced;
      logic replace_valid;
      logic replace_dirty;
      logic write_through;
   } baet_req_s;

   // Cache line actions toward the cache
   typedef struct packed {
      logic invalidate;
      logic restore_dirty;
      logic keep_valid;
      logic update_wt;
      logic fill_done;
   } baet_cache_s;
endpackage

// file: baet_unit.sv
`timescale 1ns/1ps
module baet_unit
   import baet_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic transfer_acknowledge_n,
   input wire logic transfer_error_ack_n,
   input wire logic autovector_request_n,
   input wire logic [2:0] interrupt_level_in_n,
   input wire logic [31:0] data_in,
   input wire logic iack_start,
   input wire logic breakpoint_instr,
   input wire logic req_valid,
   input wire baet_req_s req,
   input wire logic prefetch_used,
   input wire logic prefetch_flush,
   output baet_attr_s bus_attr,
   output logic bus_active,
   output logic busy,
   output logic [7:0] vector_number,
   output logic take_interrupt,
   output logic take_illegal,
   output logic access_error,
   output logic line_not_cached,
   output baet_cache_s cache_act
);
   // ------------------------------------------------------------
   // Termination decode
   // ------------------------------------------------------------
   baet_term_e term;
   always_comb begin
      case ({transfer_acknowledge_n, transfer_error_ack_n})
         2'b01: term = BAET_TERM_NORMAL;
         2'b10: term = BAET_TERM_BERR;
         2'b00: term = BAET_TERM_RETRY;
         default: term = BAET_TERM_WAIT;
      endcase
   end
   baet_state_e state_q;
   baet_req_s req_q;
   logic [2:0] level_q;
   logic [1:0] beat_q;
   logic pf_err_q;
   logic in_cycle;
   assign in_cycle = state_q == BAET_IACK || state_q == BAET_BREAK || state_q == BAET_XFER;
   // Error on this beat raises an exception now
   logic err_now;
   always_comb begin
      err_now = 1'b0;
      if (req_q.write || req_q.push) begin
         err_now = 1'b1;
      end else if (!req_q.line) begin
         err_now = !req_q.prefetch;
      end else if (req_q.misaligned && beat_q <= BAET_MISALIGN_LAST) begin
         err_now = 1'b1;
      end else begin
         err_now = beat_q == req_q.wanted_beat && !req_q.prefetch;
      end
   end

   // ------------------------------------------------------------
   // Cycle sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= BAET_IDLE;
         req_q <= '0;
         level_q <= 3'h0;
         beat_q <= 2'h0;
      end else begin
         case (state_q)
            BAET_IDLE: begin
               beat_q <= 2'h0;
               if (iack_start) begin
                  level_q <= ~interrupt_level_in_n;
                  state_q <= BAET_IACK;
               end else if (breakpoint_instr) begin
                  state_q <= BAET_BREAK;
               end else if (req_valid) begin
                  req_q <= req;
                  state_q <= BAET_XFER;
               end
            end
            BAET_IACK: begin
               // Retry keeps state, so the cycle reruns unchanged
               if (term == BAET_TERM_NORMAL || term == BAET_TERM_BERR) begin
                  state_q <= BAET_DONE;
               end
            end
            BAET_BREAK: begin
               if (term != BAET_TERM_WAIT) begin
                  state_q <= BAET_DONE;
               end
            end
            BAET_XFER: begin
               if (term == BAET_TERM_BERR) begin
                  state_q <= BAET_DONE;
               end else if (term == BAET_TERM_RETRY && req_q.line && beat_q != 2'h0) begin
                  state_q <= BAET_DONE;
               end else if (term == BAET_TERM_NORMAL) begin
                  if (req_q.line && beat_q != BAET_LINE_BEATS_M1) begin
                     beat_q <= beat_q + 2'h1;
                  end else begin
                     state_q <= BAET_DONE;
                  end
               end
               // Retry on first beat repeats with held req_q
            end
            BAET_DONE: state_q <= BAET_IDLE;
            default: state_q <= BAET_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Bus attribute drive
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bus_attr <= '0;
         bus_active <= 1'b0;
         busy <= 1'b0;
      end else begin
         busy <= state_q != BAET_IDLE || iack_start || breakpoint_instr || req_valid;
         bus_active <= 1'b0;
         bus_attr <= '0;
         if (state_q == BAET_IDLE && iack_start) begin
            bus_active <= 1'b1;
            bus_attr.transfer_type <= BAET_TT_ACK;
            bus_attr.read <= 1'b1;
            bus_attr.addr <= BAET_ADDR_IACK;
            bus_attr.transfer_modifier <= ~interrupt_level_in_n;
         end else if (state_q == BAET_IDLE && breakpoint_instr) begin
            bus_active <= 1'b1;
            bus_attr.transfer_type <= BAET_TT_ACK;
            bus_attr.read <= 1'b1;
            bus_attr.addr <= BAET_ADDR_BREAK;
            bus_attr.transfer_modifier <= BAET_TM_BREAK;
         end else if (state_q == BAET_IDLE && req_valid) begin
            bus_active <= 1'b1;
            bus_attr.transfer_type <= BAET_TT_NORMAL;
            bus_attr.read <= !req.write;
            bus_attr.addr <= req.addr;
            bus_attr.transfer_modifier <= req.tm;
         end else if (in_cycle && state_q != BAET_DONE) begin
            // Attributes stand through waits and through retries, except a retry of BREAK or of a later line beat
            bus_active <= 1'b1;
            bus_attr <= bus_attr;
            if (state_q == BAET_IACK || state_q == BAET_BREAK) begin
               if (term != BAET_TERM_WAIT && (state_q == BAET_BREAK || term != BAET_TERM_RETRY)) begin
                  bus_active <= 1'b0;
                  bus_attr <= '0;
               end
            end else if (term == BAET_TERM_BERR
                         || (term == BAET_TERM_RETRY && req_q.line && beat_q != 2'h0)
                         || (term == BAET_TERM_NORMAL
                             && (!req_q.line || beat_q == BAET_LINE_BEATS_M1))) begin
               bus_active <= 1'b0;
               bus_attr <= '0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Vector and exception results
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         vector_number <= 8'h00;
         take_interrupt <= 1'b0;
         take_illegal <= 1'b0;
      end else begin
         take_interrupt <= 1'b0;
         take_illegal <= 1'b0;
         if (state_q == BAET_IACK) begin
            if (term == BAET_TERM_NORMAL) begin
               take_interrupt <= 1'b1;
               if (!autovector_request_n) begin
                  vector_number <= BAET_AUTOVEC_BASE + {5'h00, level_q};
               end else begin
                  vector_number <= data_in[7:0];
               end
            end else if (term == BAET_TERM_BERR) begin
               take_interrupt <= 1'b1;
               vector_number <= BAET_SPURIOUS_VEC;
            end
         end
         if (state_q == BAET_BREAK && term != BAET_TERM_WAIT) begin
            take_illegal <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Access error timing
   // ------------------------------------------------------------
   logic berr_beat;
   assign berr_beat = state_q == BAET_XFER && (term == BAET_TERM_BERR
      || (term == BAET_TERM_RETRY && req_q.line && beat_q != 2'h0));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pf_err_q <= 1'b0;
         access_error <= 1'b0;
         line_not_cached <= 1'b0;
      end else begin
         access_error <= 1'b0;
         line_not_cached <= 1'b0;
         if (berr_beat && err_now) begin
            access_error <= 1'b1;
         end else if (berr_beat && req_q.prefetch && !req_q.line) begin
            pf_err_q <= 1'b1;
         end else if (pf_err_q && prefetch_used) begin
            access_error <= 1'b1;
            pf_err_q <= 1'b0;
         end else if (pf_err_q && prefetch_flush) begin
            pf_err_q <= 1'b0;
         end
         if (berr_beat && req_q.line && !req_q.write && !req_q.push) begin
            line_not_cached <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Cache line actions
   // ------------------------------------------------------------
   logic fill;
   assign fill = req_q.line && !req_q.write && !req_q.push;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cache_act <= '0;
      end else begin
         cache_act <= '0;
         if (state_q == BAET_IDLE && req_valid && !iack_start && !breakpoint_instr) begin
            cache_act.invalidate <= req.line && !req.write && !req.push
                                    && req.replace_valid;
            cache_act.update_wt <= req.write && req.write_through;
         end
         if (berr_beat && fill && req_q.replace_dirty) begin
            cache_act.restore_dirty <= 1'b1;
         end
         if (berr_beat && req_q.push) begin
            cache_act.invalidate <= req_q.push_forced;
            cache_act.keep_valid <= !req_q.push_forced;
         end
         if (state_q == BAET_XFER && fill && term == BAET_TERM_NORMAL
             && beat_q == BAET_LINE_BEATS_M1) begin
            cache_act.fill_done <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_iack_req;
      state_q == BAET_IDLE && iack_start;
   endsequence
   property p_iack_attr;
      @(posedge clk) disable iff (!rst_n)
      s_iack_req |=> bus_active && bus_attr.transfer_type == BAET_TT_ACK && bus_attr.read
                     && bus_attr.addr == BAET_ADDR_IACK;
   endproperty
   a_iack_attr: assert property (p_iack_attr) else $error("iack attributes wrong");
   property p_break_attr;
      @(posedge clk) disable iff (!rst_n)
      (state_q == BAET_IDLE && !iack_start && breakpoint_instr) |=>
         bus_attr.addr == BAET_ADDR_BREAK && bus_attr.transfer_type == BAET_TT_ACK
         && bus_attr.transfer_modifier == BAET_TM_BREAK;
   endproperty
   a_break_attr: assert property (p_break_attr) else $error("breakpoint attributes wrong");
   property p_autovec;
      @(posedge clk) disable iff (!rst_n)
      (state_q == BAET_IACK && term == BAET_TERM_NORMAL && !autovector_request_n) |=>
         take_interrupt && vector_number == BAET_AUTOVEC_BASE + {5'h00, $past(level_q)};
   endproperty
   a_autovec: assert property (p_autovec) else $error("autovector wrong");
   property p_spurious;
      @(posedge clk) disable iff (!rst_n)
      (state_q == BAET_IACK && term == BAET_TERM_BERR) |=>
         take_interrupt && vector_number == BAET_SPURIOUS_VEC;
   endproperty
   a_spurious: assert property (p_spurious) else $error("spurious vector wrong");
   property p_iack_retry;
      @(posedge clk) disable iff (!rst_n)
      (state_q == BAET_IACK && term == BAET_TERM_RETRY) |=>
         state_q == BAET_IACK && !take_interrupt && bus_active;
   endproperty
   a_iack_retry: assert property (p_iack_retry) else $error("iack not retried");
   property p_break_illegal;
      @(posedge clk) disable iff (!rst_n)
      (state_q == BAET_BREAK && term != BAET_TERM_WAIT) |=> take_illegal ##1 !take_illegal;
   endproperty
   a_break_illegal: assert property (p_break_illegal) else $error("no illegal");
   property p_wait;
      @(posedge clk) disable iff (!rst_n)
      (state_q == BAET_XFER && term == BAET_TERM_WAIT) |=>
         state_q == BAET_XFER && $stable(beat_q) && $stable(bus_attr);
   endproperty
   a_wait: assert property (p_wait) else $error("wait state lost");
   property p_berr_abort;
      @(posedge clk) disable iff (!rst_n)
      (state_q == BAET_XFER && term == BAET_TERM_BERR) |=> state_q == BAET_DONE && !bus_active;
   endproperty
   a_berr_abort: assert property (p_berr_abort) else $error("access not aborted");
   property p_write_err;
      @(posedge clk) disable iff (!rst_n)
      (state_q == BAET_XFER && term == BAET_TERM_BERR && req_q.write) |=> access_error;
   endproperty
   a_write_err: assert property (p_write_err) else $error("write error deferred");
endmodule // baet_unit

// file: baet_far_model.sv
`timescale 1ns/1ps
module baet_far_model
   import baet_pkg::*;
(
   input wire logic clk,
   input wire logic bus_active,
   input wire baet_term_e term_kind,
   input wire logic [1:0] term_beat,
   input wire logic [1:0] retries,
   input wire logic [2:0] wait_cyc,
   input wire logic autovec_on,
   input wire logic [31:0] vec_data,
   output logic transfer_acknowledge_n,
   output logic transfer_error_ack_n,
   output logic autovector_request_n,
   output logic [31:0] data_in
);
   int cnt = 0;
   int beat = 0;
   int tries = 0;
   bit hit;
   // ----------------------------------------
   // Slave, interrupter and wait-state behaviour
   // ----------------------------------------
   // Autovector request may be tied active for a whole run
   assign autovector_request_n = ~autovec_on;
   initial begin
      transfer_acknowledge_n = 1'b1;
      transfer_error_ack_n = 1'b1;
      data_in = 32'h0000_0000;
   end
   // Pulled-up terminations last one cycle; the idle data bus toggles
   always @(posedge clk) begin
      #1;
      hit = 1'b0;
      if (!transfer_acknowledge_n || !transfer_error_ack_n || !bus_active) begin
         transfer_acknowledge_n = 1'b1;
         transfer_error_ack_n = 1'b1;
         cnt = 0;
         if (!bus_active) begin
            beat = 0;
            tries = 0;
         end
      end else if (cnt < wait_cyc) begin
         cnt++;
      end else if (tries < retries) begin
         tries++;
         transfer_acknowledge_n = 1'b0;
         transfer_error_ack_n = 1'b0;
      end else if (beat != term_beat) begin
         beat++;
         transfer_acknowledge_n = 1'b0;
      end else begin
         hit = 1'b1;
         transfer_acknowledge_n = ~term_kind[0];
         transfer_error_ack_n = ~term_kind[1];
      end
      data_in = hit ? vec_data : ~data_in;
   end
endmodule // baet_far_model

// file: baet_unit_tb_top.sv
`timescale 1ns/1ps
module baet_unit_tb_top
   import baet_pkg::*;
;
   localparam logic [8:0] f_int = 9'h100;
   localparam logic [8:0] f_ill = 9'h080;
   localparam logic [8:0] f_ae = 9'h040;
   localparam logic [8:0] f_lnc = 9'h020;
   localparam logic [8:0] f_inv = 9'h010;
   localparam logic [8:0] f_rst = 9'h008;
   localparam logic [8:0] f_keep = 9'h004;
   localparam logic [8:0] f_wt = 9'h002;
   localparam logic [8:0] f_done = 9'h001;
   logic clk, rst_n, iack_start, breakpoint_instr, req_valid, prefetch_used, prefetch_flush;
   logic ack_n, err_n, autovec_n, autovec_on, clr, bus_active, busy, take_interrupt, take_illegal;
   logic access_error, line_not_cached, moved, prev_act;
   logic [2:0] ipl_n, wait_cyc;
   logic [1:0] term_beat, retries;
   logic [7:0] vector_number;
   logic [8:0] seen;
   logic [31:0] data_in, vec_data;
   baet_req_s req;
   baet_term_e term_kind;
   baet_attr_s bus_attr, first_attr, prev_attr;
   baet_cache_s cache_act;
   int act_cyc;
   int checks = 0;
   int n_fail = 0;

   baet_unit i_baet_unit (.clk(clk), .rst_n(rst_n), .transfer_acknowledge_n(ack_n),
      .transfer_error_ack_n(err_n), .autovector_request_n(autovec_n),
      .interrupt_level_in_n(ipl_n), .data_in(data_in), .iack_start(iack_start),
      .breakpoint_instr(breakpoint_instr), .req_valid(req_valid), .req(req),
      .prefetch_used(prefetch_used), .prefetch_flush(prefetch_flush), .bus_attr(bus_attr),
      .bus_active(bus_active), .busy(busy), .vector_number(vector_number),
      .take_interrupt(take_interrupt), .take_illegal(take_illegal),
      .access_error(access_error), .line_not_cached(line_not_cached), .cache_act(cache_act));

   baet_far_model i_baet_far_model (.clk(clk), .bus_active(bus_active), .term_kind(term_kind),
      .term_beat(term_beat), .retries(retries), .wait_cyc(wait_cyc), .autovec_on(autovec_on),
      .vec_data(vec_data), .transfer_acknowledge_n(ack_n), .transfer_error_ack_n(err_n),
      .autovector_request_n(autovec_n), .data_in(data_in));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ----------------------------------------
   // Monitor: sticky results, cycle count
   // ----------------------------------------
   always @(posedge clk) begin
      if (clr) begin
         seen <= 9'h000;
         act_cyc <= 0;
         moved <= 1'b0;
      end else begin
         seen <= seen | {take_interrupt, take_illegal, access_error, line_not_cached, cache_act};
         if (bus_active) act_cyc <= act_cyc + 1;
         if (bus_active && !prev_act) first_attr <= bus_attr;
         if (bus_active && prev_act && bus_attr !== prev_attr) moved <= 1'b1;
      end
      prev_act <= bus_active;
      prev_attr <= bus_attr;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic test_done();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_attr(input baet_attr_s exp);
      checks++;
      if (first_attr !== exp) begin
         n_fail++;
         $display("unexpected bus_attr: expected %h seen %h", exp, first_attr);
      end
   endtask

   task automatic outcome(input logic [8:0] f);
      cmp_val("results", 32'(f), 32'(seen));
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic far(input baet_term_e k, input int b, input int r, input int w,
         input logic av, input logic [31:0] d);
      term_kind = k;
      term_beat = b[1:0];
      retries = r[1:0];
      wait_cyc = w[2:0];
      autovec_on = av;
      vec_data = d;
   endtask

   task automatic launch(input int kind);
      int n;
      n = 0;
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      iack_start = (kind == 0);
      breakpoint_instr = (kind == 1);
      req_valid = (kind == 2);
      cyc(1);
      iack_start = 1'b0;
      breakpoint_instr = 1'b0;
      req_valid = 1'b0;
      while (busy !== 1'b0 && n < 200) begin
         cyc(1);
         n++;
      end
      if (n >= 200) begin
         n_fail++;
         test_done();
      end
      cyc(3);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic sc_iack(input logic av);
      logic [7:0] v;
      for (int l = 1; l < 8; l++) begin
         ipl_n = ~l[2:0];
         v = av ? 8'(l) + 8'h18 : {5'h08, l[2:0]};
         far(BAET_TERM_NORMAL, 0, 0, l, av, {24'h5A_5A5A, 5'h08, l[2:0]});
         launch(0);
         cmp_attr(baet_attr_s'{BAET_TT_ACK, l[2:0], BAET_ADDR_IACK, 1'b1});
         cmp_val("vector", 32'(v), 32'(vector_number));
         cmp_val("cycles", 32'(l + 1), 32'(act_cyc));
         outcome(f_int);
      end
   endtask

   task automatic sc_spurious();
      ipl_n = 3'h2;
      far(BAET_TERM_BERR, 0, 0, 3, 1'b1, 32'h0000_0077);
      launch(0);
      cmp_val("vector", 32'h0000_0018, 32'(vector_number));
      outcome(f_int);
   endtask

   task automatic sc_iack_retry();
      ipl_n = 3'h4;
      far(BAET_TERM_NORMAL, 0, 2, 0, 1'b0, 32'h0000_0066);
      launch(0);
      cmp_val("vector", 32'h0000_0066, 32'(vector_number));
      cmp_val("moved", 32'h0000_0000, 32'(moved));
      cmp_val("cycles", 32'h0000_0005, 32'(act_cyc));
   endtask

   task automatic sc_break();
      baet_term_e k[2] = '{BAET_TERM_NORMAL, BAET_TERM_BERR};
      foreach (k[i]) begin
         far(k[i], 0, 0, i, 1'b0, 32'hFFFF_FFFF);
         launch(1);
         cmp_attr(baet_attr_s'{BAET_TT_ACK, 3'h0, 32'h0000_0000, 1'b1});
         outcome(f_ill);
      end
   endtask

   task automatic sc_write(input baet_term_e k, input logic wt, input logic [8:0] f);
      req = '0;
      req.addr = 32'h0000_1234;
      req.tm = 3'h5;
      req.write = 1'b1;
      req.write_through = wt;
      far(k, 0, 0, 4, 1'b0, 32'h0000_0000);
      launch(2);
      cmp_attr(baet_attr_s'{BAET_TT_NORMAL, 3'h5, 32'h0000_1234, 1'b0});
      cmp_val("cycles", 32'h0000_0005, 32'(act_cyc));
      outcome(f);
   endtask

   task automatic sc_read_retry();
      req = '0;
      req.addr = 32'h0000_0A00;
      req.tm = 3'h2;
      far(BAET_TERM_NORMAL, 0, 1, 1, 1'b0, 32'h0000_0000);
      launch(2);
      cmp_val("moved", 32'h0000_0000, 32'(moved));
      cmp_val("cycles", 32'h0000_0005, 32'(act_cyc));
      outcome(9'h000);
   endtask

   task automatic line_case(input baet_term_e k, input int b, input logic [1:0] want,
         input logic mis, input logic rv, input int r, input logic [8:0] f);
      req = '0;
      req.addr = 32'h0000_2000;
      req.line = 1'b1;
      req.misaligned = mis;
      req.wanted_beat = want;
      req.replace_valid = rv;
      req.replace_dirty = rv;
      far(k, b, r, 0, 1'b0, 32'h0000_0000);
      launch(2);
      cmp_val("cycles", 32'(2 * (b + r) + 1), 32'(act_cyc));
      outcome(f);
   endtask

   task automatic sc_push(input logic forced, input logic [8:0] f);
      req = '0;
      req.addr = 32'h0000_3000;
      req.write = 1'b1;
      req.line = 1'b1;
      req.push = 1'b1;
      req.push_forced = forced;
      far(BAET_TERM_BERR, 1, 0, 0, 1'b0, 32'h0000_0000);
      launch(2);
      cmp_val("cache", 32'(f), 32'(seen & (f_keep | f_inv)));
   endtask

   task automatic sc_prefetch(input logic flush, input logic [8:0] f);
      req = '0;
      req.addr = 32'h0000_4000;
      req.prefetch = 1'b1;
      far(BAET_TERM_BERR, 0, 0, 0, 1'b0, 32'h0000_0000);
      launch(2);
      outcome(9'h000);
      prefetch_flush = flush;
      cyc(1);
      prefetch_flush = 1'b0;
      prefetch_used = 1'b1;
      cyc(1);
      prefetch_used = 1'b0;
      cyc(3);
      outcome(f);
   endtask

   task automatic sc_reset();
      far(BAET_TERM_NORMAL, 0, 0, 7, 1'b0, 32'h0000_0011);
      ipl_n = 3'h1;
      iack_start = 1'b1;
      cyc(1);
      iack_start = 1'b0;
      cyc(2);
      cmp_val("bus_active", 32'h0000_0001, 32'(bus_active));
      rst_n = 1'b0;
      cyc(2);
      cmp_val("bus_active", 32'h0000_0000, 32'(bus_active));
      cmp_val("bus_attr", 32'h0000_0000, bus_attr.addr);
      cmp_val("reset state", 32'h0000_0000, 32'({busy, cache_act, vector_number}));
      rst_n = 1'b1;
      far(BAET_TERM_NORMAL, 0, 0, 0, 1'b0, 32'h0000_0011);
      launch(0);
      cmp_val("vector", 32'h0000_0011, 32'(vector_number));
      outcome(f_int);
   endtask

   initial begin
      rst_n = 1'b0;
      iack_start = 1'b0;
      breakpoint_instr = 1'b0;
      req_valid = 1'b0;
      prefetch_used = 1'b0;
      prefetch_flush = 1'b0;
      clr = 1'b1;
      ipl_n = 3'h7;
      req = '0;
      far(BAET_TERM_NORMAL, 0, 0, 0, 1'b0, 32'h0000_0000);
      repeat (16) @(posedge clk);
      #1;
      rst_n = 1'b1;
      cyc(2);
      sc_iack(1'b0);
      sc_iack(1'b1);
      sc_spurious();
      sc_iack_retry();
      sc_break();
      sc_write(BAET_TERM_NORMAL, 1'b0, 9'h000);
      sc_write(BAET_TERM_BERR, 1'b0, f_ae);
      sc_write(BAET_TERM_BERR, 1'b1, f_ae | f_wt);
      sc_read_retry();
      line_case(BAET_TERM_BERR, 2, 2'h0, 1'b0, 1'b1, 0, f_lnc | f_inv | f_rst);
      line_case(BAET_TERM_BERR, 2, 2'h2, 1'b0, 1'b0, 0, f_ae | f_lnc);
      line_case(BAET_TERM_BERR, 1, 2'h0, 1'b1, 1'b0, 0, f_ae | f_lnc);
      line_case(BAET_TERM_RETRY, 3, 2'h3, 1'b0, 1'b0, 0, f_ae | f_lnc);
      line_case(BAET_TERM_NORMAL, 3, 2'h0, 1'b0, 1'b1, 1, f_inv | f_done);
      sc_push(1'b0, f_keep);
      sc_push(1'b1, f_inv);
      sc_prefetch(1'b0, f_ae);
      sc_prefetch(1'b1, 9'h000);
      sc_reset();
      test_done();
   end
endmodule // baet_unit_tb_top
